// File: src/pdcs_pkg.sv
// constants and types of the port device control and status register pair
package pdcs_pkg;

   // register byte addresses
   localparam logic [31:0] PDCS_DEVCS_ADDR = 32'h0000_00c8;
   localparam logic [31:0] PDCS_IRQ_STATUS_ADDR = 32'h0000_00e0;
   localparam logic [31:0] PDCS_IRQ_MASK_ADDR = 32'h0000_00e4;
   localparam int PDCS_ADDR_W = 12;

   // number of error classes: correctable, non-fatal, fatal, unsupported request
   localparam int PDCS_NUM_ERR = 4;

   // control half field positions
   localparam int PDCS_ERR_EN_LSB = 0;
   localparam int PDCS_RELAX_ORD_BIT = 4;
   localparam int PDCS_MPS_LSB = 5;
   localparam int PDCS_MPS_MSB = 7;
   localparam int PDCS_EXT_TAG_BIT = 8;
   localparam int PDCS_PHANTOM_BIT = 9;
   localparam int PDCS_AUX_PM_BIT = 10;
   localparam int PDCS_NO_SNOOP_BIT = 11;
   localparam int PDCS_MRRS_LSB = 12;
   localparam int PDCS_MRRS_MSB = 14;

   // status half field positions
   localparam int PDCS_ERR_DET_LSB = 16;
   localparam int PDCS_AUX_DET_BIT = 20;
   localparam int PDCS_TRANS_PEND_BIT = 21;

   // payload size codes
   localparam logic [2:0] PDCS_MPS_128 = 3'h0;
   localparam logic [2:0] PDCS_MPS_256 = 3'h1;
   localparam logic [2:0] PDCS_MPS_512 = 3'h2;

   // reset values and hardwired field values
   localparam logic [3:0] PDCS_ERR_EN_RST = 4'h0;
   localparam logic [2:0] PDCS_MPS_RST = PDCS_MPS_128;
   localparam logic [2:0] PDCS_MPS_SUP_RST = PDCS_MPS_256;
   localparam logic PDCS_AUX_PM_RST = 1'h0;
   localparam logic PDCS_AUX_DET_RST = 1'h1;
   localparam logic [3:0] PDCS_IRQ_MASK_RST = 4'h0;
   localparam logic [2:0] PDCS_MRRS_VAL = 3'h0;
   localparam logic PDCS_HARD_ZERO = 1'h0;

   // ahb encodings
   localparam logic [1:0] PDCS_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PDCS_HTRANS_SEQ = 2'h3;
   localparam logic PDCS_HRESP_OKAY = 1'h0;

   typedef enum logic [1:0] {
      PDCS_BS_IDLE,
      PDCS_BS_WRITE,
      PDCS_BS_READ
   } pdcs_bus_state_t;

endpackage

// File: src/pdcs_sticky_flag.sv
// one write-one-to-clear sticky flag in which a set beats a clear
module pdcs_sticky_flag (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic set_i,
   input wire logic clear_i,
   output logic flag_o
);

   logic flag_r;
   logic flag_nxt;

   always_comb begin
      flag_nxt = flag_r;
      if (clear_i) begin
         flag_nxt = 1'b0;
      end
      if (set_i) begin
         flag_nxt = 1'b1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flag_r <= 1'b0;
      end else begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;

endmodule

// File: src/pdcs_port_devctl.sv
// device control and device status register pair of one switch port, ahb-lite slave
//
// Behaviour
// - four read-write error reporting enables at bits 0 to 3, reset zero
// - relaxed ordering enable at bit 4 is read-only zero
// - payload size limit at bits 7:5, reset 000b, clamped to supported size
// - codes 128/256/512 bytes; supported size 001b or 010b from strap
// - extended tag and phantom function enables read zero whatever is written
// - auxiliary power management enable at bit 10, read-write, reset zero
// - no-snoop enable at bit 11 is read-only zero
// - status bits 16 to 19 log each error class, write one clears
// - auxiliary power detected flag at bit 20, read-only, reset one
// - transactions pending at bit 21 hardwired to zero
//
// byte addresses: 0xc8 control and status halves, 0xe0 irq status, 0xe4 irq mask
// irq status is kept apart from status bits 19:16, each cleared on its own
module pdcs_port_devctl
   import pdcs_pkg::*;
#(
   parameter int NUM_ERR = PDCS_NUM_ERR
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic large_payload_strap,
   input wire logic aux_power_sense,
   input wire logic [NUM_ERR-1:0] err_detect,
   output logic [NUM_ERR-1:0] err_report,
   output logic [2:0] max_payload_size,
   output logic aux_power_pm_en,
   output logic irq
);

   ////////////////////////////////////////////////////////////////
   // bus phase tracking

   pdcs_bus_state_t bus_state_r;
   pdcs_bus_state_t bus_state_nxt;
   logic [PDCS_ADDR_W-1:0] addr_r;
   logic [PDCS_ADDR_W-1:0] addr_nxt;
   logic hreadyout_r;
   logic hreadyout_nxt;
   logic [31:0] hrdata_r;
   logic [31:0] hrdata_nxt;
   logic addr_take;

   // only word transfers are expected, so the size is not decoded
   assign addr_take = hsel && hready && (htrans == PDCS_HTRANS_NONSEQ || htrans == PDCS_HTRANS_SEQ);

   always_comb begin
      bus_state_nxt = bus_state_r;
      addr_nxt = addr_r;
      hreadyout_nxt = 1'b1;
      unique case (bus_state_r)
         PDCS_BS_IDLE, PDCS_BS_WRITE: begin
            bus_state_nxt = PDCS_BS_IDLE;
            if (addr_take) begin
               addr_nxt = haddr[PDCS_ADDR_W-1:0];
               if (hwrite) begin
                  bus_state_nxt = PDCS_BS_WRITE;
               end else begin
                  // reads take one wait state so they see the last write
                  bus_state_nxt = PDCS_BS_READ;
                  hreadyout_nxt = 1'b0;
               end
            end
         end
         PDCS_BS_READ: begin
            bus_state_nxt = PDCS_BS_IDLE;
         end
         default: begin
            bus_state_nxt = PDCS_BS_IDLE;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bus_state_r <= PDCS_BS_IDLE;
         addr_r <= '0;
         hreadyout_r <= 1'b1;
      end else begin
         bus_state_r <= bus_state_nxt;
         addr_r <= addr_nxt;
         hreadyout_r <= hreadyout_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // address decode for the data phase

   logic wr_devcs;
   logic wr_irq_status;
   logic wr_irq_mask;
   logic sel_devcs;
   logic sel_irq_status;
   logic sel_irq_mask;

   assign sel_devcs = (addr_r == PDCS_DEVCS_ADDR[PDCS_ADDR_W-1:0]);
   assign sel_irq_status = (addr_r == PDCS_IRQ_STATUS_ADDR[PDCS_ADDR_W-1:0]);
   assign sel_irq_mask = (addr_r == PDCS_IRQ_MASK_ADDR[PDCS_ADDR_W-1:0]);
   assign wr_devcs = (bus_state_r == PDCS_BS_WRITE) && sel_devcs;
   assign wr_irq_status = (bus_state_r == PDCS_BS_WRITE) && sel_irq_status;
   assign wr_irq_mask = (bus_state_r == PDCS_BS_WRITE) && sel_irq_mask;

   ////////////////////////////////////////////////////////////////
   // supported payload size, caught from the strap after reset

   logic [2:0] mps_sup_r;
   logic [2:0] mps_sup_nxt;
   logic strap_taken_r;
   logic strap_taken_nxt;

   always_comb begin
      mps_sup_nxt = mps_sup_r;
      strap_taken_nxt = 1'b1;
      // later strap moves are ignored until the next reset
      if (!strap_taken_r) begin
         mps_sup_nxt = large_payload_strap ? PDCS_MPS_512 : PDCS_MPS_256;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mps_sup_r <= PDCS_MPS_SUP_RST;
         strap_taken_r <= 1'b0;
      end else begin
         mps_sup_r <= mps_sup_nxt;
         strap_taken_r <= strap_taken_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // control half

   logic [NUM_ERR-1:0] err_en_r;
   logic [NUM_ERR-1:0] err_en_nxt;
   logic [2:0] mps_r;
   logic [2:0] mps_nxt;
   logic aux_pm_r;
   logic aux_pm_nxt;
   logic [2:0] mps_wr;
   logic [NUM_ERR-1:0] err_en_wr;
   logic aux_pm_wr;

   // write fields picked from the data phase word
   assign mps_wr = hwdata[PDCS_MPS_MSB:PDCS_MPS_LSB];
   assign err_en_wr = hwdata[PDCS_ERR_EN_LSB +: NUM_ERR];
   assign aux_pm_wr = hwdata[PDCS_AUX_PM_BIT];

   always_comb begin
      err_en_nxt = err_en_r;
      mps_nxt = mps_r;
      aux_pm_nxt = aux_pm_r;
      if (wr_devcs) begin
         err_en_nxt = err_en_wr;
         mps_nxt = (mps_wr > mps_sup_r) ? mps_sup_r : mps_wr;
         aux_pm_nxt = aux_pm_wr;
      end
      // a limit above the supported size is pulled down to it, with or without a write
      if (mps_nxt > mps_sup_r) begin
         mps_nxt = mps_sup_r;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_en_r <= PDCS_ERR_EN_RST[NUM_ERR-1:0];
         mps_r <= PDCS_MPS_RST;
         aux_pm_r <= PDCS_AUX_PM_RST;
      end else begin
         err_en_r <= err_en_nxt;
         mps_r <= mps_nxt;
         aux_pm_r <= aux_pm_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // status half and interrupt flags

   logic [NUM_ERR-1:0] err_det;
   logic [NUM_ERR-1:0] irq_flag;
   logic [NUM_ERR-1:0] irq_mask_r;
   logic [NUM_ERR-1:0] irq_mask_nxt;
   logic aux_det_r;
   logic aux_det_nxt;
   logic [NUM_ERR-1:0] err_clr;
   logic [NUM_ERR-1:0] irq_clr;

   // write one clears, a zero leaves the flag alone
   always_comb begin
      err_clr = '0;
      irq_clr = '0;
      if (wr_devcs) begin
         err_clr = hwdata[PDCS_ERR_DET_LSB +: NUM_ERR];
      end
      if (wr_irq_status) begin
         irq_clr = hwdata[NUM_ERR-1:0];
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < NUM_ERR; gi++) begin : g_flag
         // logged whatever the reporting enable holds
         // set beats clear so an error in the clearing cycle is kept
         pdcs_sticky_flag u_err_det (
            .hclk(hclk),
            .hresetn(hresetn),
            .set_i(err_detect[gi]),
            .clear_i(err_clr[gi]),
            .flag_o(err_det[gi])
         );
         pdcs_sticky_flag u_irq_flag (
            .hclk(hclk),
            .hresetn(hresetn),
            .set_i(err_detect[gi]),
            .clear_i(irq_clr[gi]),
            .flag_o(irq_flag[gi])
         );
      end
   endgenerate

   always_comb begin
      irq_mask_nxt = irq_mask_r;
      if (wr_irq_mask) begin
         irq_mask_nxt = hwdata[NUM_ERR-1:0];
      end
      aux_det_nxt = aux_power_sense;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask_r <= PDCS_IRQ_MASK_RST[NUM_ERR-1:0];
         aux_det_r <= PDCS_AUX_DET_RST;
      end else begin
         irq_mask_r <= irq_mask_nxt;
         aux_det_r <= aux_det_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // read data assembly

   logic [31:0] devcs_word;

   always_comb begin
      devcs_word = '0;
      devcs_word[PDCS_ERR_EN_LSB +: NUM_ERR] = err_en_r;
      devcs_word[PDCS_RELAX_ORD_BIT] = PDCS_HARD_ZERO;
      devcs_word[PDCS_MPS_MSB:PDCS_MPS_LSB] = mps_r;
      devcs_word[PDCS_EXT_TAG_BIT] = PDCS_HARD_ZERO;
      devcs_word[PDCS_PHANTOM_BIT] = PDCS_HARD_ZERO;
      devcs_word[PDCS_AUX_PM_BIT] = aux_pm_r;
      devcs_word[PDCS_NO_SNOOP_BIT] = PDCS_HARD_ZERO;
      devcs_word[PDCS_MRRS_MSB:PDCS_MRRS_LSB] = PDCS_MRRS_VAL;
      devcs_word[PDCS_ERR_DET_LSB +: NUM_ERR] = err_det;
      devcs_word[PDCS_AUX_DET_BIT] = aux_det_r;
      devcs_word[PDCS_TRANS_PEND_BIT] = PDCS_HARD_ZERO;
   end

   always_comb begin
      hrdata_nxt = hrdata_r;
      if (bus_state_r == PDCS_BS_READ) begin
         // unmapped offsets read as zero
         hrdata_nxt = '0;
         if (sel_devcs) begin
            hrdata_nxt = devcs_word;
         end else if (sel_irq_status) begin
            hrdata_nxt[NUM_ERR-1:0] = irq_flag;
         end else if (sel_irq_mask) begin
            hrdata_nxt[NUM_ERR-1:0] = irq_mask_r;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= '0;
      end else begin
         hrdata_r <= hrdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////
   // registered side outputs

   logic [NUM_ERR-1:0] err_report_r;
   logic [NUM_ERR-1:0] err_report_nxt;
   logic irq_r;
   logic irq_nxt;
   logic [2:0] mps_out_r;
   logic [2:0] mps_out_nxt;
   logic aux_pm_out_r;
   logic aux_pm_out_nxt;
   logic hresp_r;
   logic hresp_nxt;

   always_comb begin
      err_report_nxt = err_detect & err_en_r;
      irq_nxt = |(irq_flag & irq_mask_r);
      mps_out_nxt = mps_r;
      aux_pm_out_nxt = aux_pm_r;
      // no error responses are ever given
      hresp_nxt = PDCS_HRESP_OKAY;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_report_r <= '0;
         irq_r <= 1'b0;
         mps_out_r <= PDCS_MPS_RST;
         aux_pm_out_r <= PDCS_AUX_PM_RST;
         hresp_r <= PDCS_HRESP_OKAY;
      end else begin
         err_report_r <= err_report_nxt;
         irq_r <= irq_nxt;
         mps_out_r <= mps_out_nxt;
         aux_pm_out_r <= aux_pm_out_nxt;
         hresp_r <= hresp_nxt;
      end
   end

   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;
   assign err_report = err_report_r;
   assign irq = irq_r;
   assign max_payload_size = mps_out_r;
   assign aux_power_pm_en = aux_pm_out_r;

endmodule

// File: sim/pdcs_port_devctl_checker.sv
// bus timing and read-back assertions for the device control and status pair
module pdcs_port_devctl_checker
   import pdcs_pkg::*;
#(
   parameter int NUM_ERR = PDCS_NUM_ERR
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic large_payload_strap,
   input wire logic aux_power_sense,
   input wire logic [NUM_ERR-1:0] err_detect,
   input wire logic [NUM_ERR-1:0] err_report,
   input wire logic [2:0] max_payload_size,
   input wire logic aux_power_pm_en,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ps;
   logic take_rd;
   logic take_wr;
   assign take_rd = hsel & hready & htrans[1] & !hwrite;
   assign take_wr = hsel & hready & htrans[1] & hwrite;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   ////////////////////////////////////////////////////////////////////////////
   AST_RD_WAIT: assert property (take_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   AST_WR_NO_WAIT: assert property (take_wr |=> hreadyout)
      else $error("write was stalled");
   AST_OKAY: assert property (hresp == PDCS_HRESP_OKAY)
      else $error("response not okay");
   AST_RSVD_ZERO: assert property ($rose(hreadyout) |-> hrdata[31:22] == 10'h0 && !hrdata[15])
      else $error("reserved bits read nonzero");
   AST_RO_ZERO: assert property ($rose(hreadyout) |-> hrdata[14:11] == 4'h0
      && hrdata[9:8] == 2'h0 && !hrdata[4])
      else $error("hardwired bits read nonzero");
   AST_PEND_ZERO: assert property ($rose(hreadyout) |-> !hrdata[21])
      else $error("transactions pending set");
   AST_RDATA_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
      else $error("read data changed outside read");
   AST_REPORT_CAUSE: assert property ((err_report & ~$past(err_detect)) == '0)
      else $error("error report without detection");
   AST_MPS_RANGE: assert property (max_payload_size <= PDCS_MPS_512)
      else $error("payload size above largest code");
   COV_READ: cover property (take_rd);
   COV_REPORT: cover property (|err_report);
   COV_IRQ: cover property ($rose(irq));
endmodule
bind pdcs_port_devctl pdcs_port_devctl_checker #(.NUM_ERR(NUM_ERR)) u_pdcs_port_devctl_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
   .hrdata(hrdata), .large_payload_strap(large_payload_strap), .aux_power_sense(aux_power_sense),
   .err_detect(err_detect), .err_report(err_report), .max_payload_size(max_payload_size),
   .aux_power_pm_en(aux_power_pm_en), .irq(irq));

// File: sim/testbench.sv
// self-checking bench for the device control and status register pair
`define CHK(n, e, s) begin \
   total_checks++; \
   if ((s) !== (e)) begin \
      failures++; \
      $display("BAD %s exp %h got %h", n, e, s); \
   end \
end
module testbench
   import pdcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, large_payload_strap = 1'b0;
   logic aux_power_sense = 1'b1;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
   logic [1:0] htrans = 2'h0;
   logic [3:0] err_detect = 4'h0, err_report;
   logic hready, hreadyout, hresp, aux_pm, irq;
   logic [2:0] mps;
   int failures = 0, total_checks = 0;
   initial forever #12.5 hclk = ~hclk;
   assign hready = hreadyout;
   pdcs_port_devctl #(.NUM_ERR(PDCS_NUM_ERR)) u_pdcs_port_devctl (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .large_payload_strap(large_payload_strap), .aux_power_sense(aux_power_sense),
      .err_detect(err_detect), .err_report(err_report), .max_payload_size(mps),
      .aux_power_pm_en(aux_pm), .irq(irq));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (failures == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask
   // one single ahb transfer, entered just after a rising edge
   task automatic bus(input logic w, input logic [31:0] a, d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= PDCS_HTRANS_NONSEQ;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic chk_rd(input logic [31:0] a, e);
      bus(1'b0, a, 32'h0);
      `CHK("hrdata", e, rd)
   endtask
   task automatic pulse(input logic [3:0] v, e);
      err_detect <= v;
      @(posedge hclk);
      err_detect <= 4'h0;
      @(posedge hclk);
      `CHK("err_report", e, err_report)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (5000) @(posedge hclk);
      failures++;
      complete_run();
   end
   initial begin
      do_reset();
      chk_rd(PDCS_DEVCS_ADDR, 32'h0010_0000);
      chk_rd(PDCS_IRQ_STATUS_ADDR, 32'h0);
      chk_rd(PDCS_IRQ_MASK_ADDR, 32'h0);
      bus(1'b1, PDCS_DEVCS_ADDR, 32'hffff_ffff);
      chk_rd(PDCS_DEVCS_ADDR, 32'h0010_042f);
      `CHK("aux_pm", 1'b1, aux_pm)
      for (int c = 0; c < 8; c++) begin
         bus(1'b1, PDCS_DEVCS_ADDR, 32'(c) << 5);
         chk_rd(PDCS_DEVCS_ADDR, 32'h0010_0000 | ((c > 1 ? 32'h1 : 32'(c)) << 5));
         `CHK("mps", (c > 1) ? PDCS_MPS_256 : 3'(c), mps)
      end
      bus(1'b1, PDCS_DEVCS_ADDR, 32'h0);
      for (int i = 0; i < 4; i++) pulse(4'(1 << i), 4'h0);
      chk_rd(PDCS_DEVCS_ADDR, 32'h001f_0000);
      bus(1'b1, PDCS_DEVCS_ADDR, 32'h0000_000f);
      for (int i = 0; i < 4; i++) pulse(4'(1 << i), 4'(1 << i));
      chk_rd(PDCS_DEVCS_ADDR, 32'h001f_000f);
      bus(1'b1, PDCS_DEVCS_ADDR, 32'h0005_000f);
      chk_rd(PDCS_DEVCS_ADDR, 32'h001a_000f);
      chk_rd(PDCS_IRQ_STATUS_ADDR, 32'hf);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, PDCS_IRQ_MASK_ADDR, 32'hf);
      repeat (2) @(posedge hclk);
      `CHK("irq", 1'b1, irq)
      chk_rd(PDCS_IRQ_MASK_ADDR, 32'hf);
      bus(1'b1, PDCS_IRQ_STATUS_ADDR, 32'h5);
      chk_rd(PDCS_IRQ_STATUS_ADDR, 32'ha);
      bus(1'b1, PDCS_IRQ_STATUS_ADDR, 32'ha);
      repeat (2) @(posedge hclk);
      `CHK("irq", 1'b0, irq)
      bus(1'b1, PDCS_DEVCS_ADDR, 32'h001a_0000);
      aux_power_sense <= 1'b0;
      repeat (2) @(posedge hclk);
      chk_rd(PDCS_DEVCS_ADDR, 32'h0);
      bus(1'b1, 32'h0000_0100, 32'hffff_ffff);
      chk_rd(32'h0000_0100, 32'h0);
      large_payload_strap <= 1'b1;
      do_reset();
      bus(1'b1, PDCS_DEVCS_ADDR, 32'h0000_00e0);
      chk_rd(PDCS_DEVCS_ADDR, 32'h0000_0040);
      `CHK("mps", PDCS_MPS_512, mps)
      complete_run();
   end
endmodule
